// *** logic/ldr_regfile.sv ***
// i2c register file of the four-string led driver with fault logging
`timescale 1ns/1ps
module ldr_regfile #(
    parameter logic [6:0] I2C_ADDR = 7'h2a,
    // arbitrary revision value
    parameter logic [ldr_pkg::REV_W-1:0] REVISION = 3'h1
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic enable_i,
    input wire logic busy_i,
    input wire logic adc_load_i,
    input wire ldr_pkg::ldr_adc_t adc_i,
    input wire ldr_pkg::ldr_flt_in_t fault_i,
    output ldr_pkg::ldr_cfg_t cfg_o,
    output logic [ldr_pkg::FLT_W-1:0] fault_flags_o,
    output logic switching_halt_o
);
    localparam int SYNC_W = ldr_pkg::NUM_FSRC + 3;

    // ******************************
    // pin synchronisers
    // ******************************
    logic [SYNC_W-1:0] sync_in;
    logic [SYNC_W-1:0] sync_out;
    logic scl_s;
    logic sda_s;
    logic en_s;
    logic [ldr_pkg::NUM_FSRC-1:0] flt_s;

    assign sync_in = {fault_i, enable_i, sda_i, scl_i};

    // idle bus lines reset high so no false start is seen
    ldr_sync #(
        .W(SYNC_W),
        .RST_VAL(8'h03)
    ) u_sync (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(sync_in),
        .sync_o(sync_out)
    );

    assign scl_s = sync_out[0];
    assign sda_s = sync_out[1];
    assign en_s = sync_out[2];
    assign flt_s = sync_out[SYNC_W-1:3];

    // ******************************
    // bus condition detection
    // ******************************
    logic scl_d_r;
    logic sda_d_r;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    assign scl_rise = scl_s & ~scl_d_r;
    assign scl_fall = ~scl_s & scl_d_r;
    assign bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign bus_stop = scl_s & scl_d_r & ~sda_d_r & sda_s;

    // ******************************
    // register state
    // ******************************
    ldr_pkg::ldr_cfg_t cfg_r;
    ldr_pkg::ldr_adc_t adc_r;
    logic [ldr_pkg::FLT_W-1:0] flags_r;
    logic halt_r;
    logic arm_r;

    // ******************************
    // i2c slave state machine
    // ******************************
    ldr_pkg::ldr_i2c_st_t state_r;
    logic [3:0] bitcnt_r;
    logic [7:0] shift_r;
    logic rw_r;
    logic [ldr_pkg::PTR_W-1:0] ptr_r;
    logic [ldr_pkg::PTR_W-1:0] ptr_inc;
    logic oe_n_r;
    logic wr_en_r;
    logic [ldr_pkg::PTR_W-1:0] wr_addr_r;
    logic [7:0] wr_data_r;
    logic rd_done_r;
    logic [ldr_pkg::PTR_W-1:0] rd_addr_r;
    logic cmd_ok;
    logic [7:0] rd_mux;

    assign ptr_inc = (ptr_r == ldr_pkg::OFS_LAST[ldr_pkg::PTR_W-1:0]) ?
        '0 : ptr_r + 4'h1;
    assign cmd_ok = (shift_r <= ldr_pkg::OFS_LAST) && !busy_i;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state_r <= ldr_pkg::ST_IDLE;
            bitcnt_r <= 4'h0;
            shift_r <= 8'h00;
            rw_r <= 1'b0;
            ptr_r <= '0;
            oe_n_r <= 1'b1;
            wr_en_r <= 1'b0;
            wr_addr_r <= '0;
            wr_data_r <= 8'h00;
            rd_done_r <= 1'b0;
            rd_addr_r <= '0;
        end else begin
            wr_en_r <= 1'b0;
            rd_done_r <= 1'b0;
            if (bus_start) begin
                state_r <= ldr_pkg::ST_ADDR;
                bitcnt_r <= 4'h0;
                oe_n_r <= 1'b1;
            end else if (bus_stop) begin
                state_r <= ldr_pkg::ST_IDLE;
                oe_n_r <= 1'b1;
            end else begin
                case (state_r)
                    ldr_pkg::ST_IDLE: begin
                        oe_n_r <= 1'b1;
                    end
                    ldr_pkg::ST_ADDR, ldr_pkg::ST_CMD, ldr_pkg::ST_WDATA: begin
                        if (scl_rise) begin
                            shift_r <= {shift_r[6:0], sda_s};
                            bitcnt_r <= bitcnt_r + 4'h1;
                        end else if (scl_fall && bitcnt_r == 4'(ldr_pkg::I2C_BITS)) begin
                            bitcnt_r <= 4'h0;
                            if (state_r == ldr_pkg::ST_ADDR) begin
                                if (shift_r[7:1] == I2C_ADDR) begin
                                    oe_n_r <= 1'b0;
                                    rw_r <= shift_r[0];
                                    state_r <= ldr_pkg::ST_ADDR_ACK;
                                end else begin
                                    state_r <= ldr_pkg::ST_IDLE;
                                end
                            end else if (state_r == ldr_pkg::ST_CMD) begin
                                if (cmd_ok) begin
                                    oe_n_r <= 1'b0;
                                    ptr_r <= shift_r[ldr_pkg::PTR_W-1:0];
                                    state_r <= ldr_pkg::ST_CMD_ACK;
                                end else begin
                                    state_r <= ldr_pkg::ST_IDLE;
                                end
                            end else begin
                                oe_n_r <= 1'b0;
                                wr_en_r <= 1'b1;
                                wr_addr_r <= ptr_r;
                                wr_data_r <= shift_r;
                                ptr_r <= ptr_inc;
                                state_r <= ldr_pkg::ST_WDATA_ACK;
                            end
                        end
                    end
                    ldr_pkg::ST_ADDR_ACK: begin
                        if (scl_fall) begin
                            bitcnt_r <= 4'h0;
                            if (rw_r) begin
                                shift_r <= rd_mux;
                                oe_n_r <= rd_mux[7];
                                state_r <= ldr_pkg::ST_RDATA;
                            end else begin
                                oe_n_r <= 1'b1;
                                state_r <= ldr_pkg::ST_CMD;
                            end
                        end
                    end
                    ldr_pkg::ST_CMD_ACK, ldr_pkg::ST_WDATA_ACK: begin
                        if (scl_fall) begin
                            oe_n_r <= 1'b1;
                            state_r <= ldr_pkg::ST_WDATA;
                        end
                    end
                    ldr_pkg::ST_RDATA: begin
                        if (scl_fall) begin
                            if (bitcnt_r == 4'(ldr_pkg::I2C_BITS - 1)) begin
                                oe_n_r <= 1'b1;
                                rd_done_r <= 1'b1;
                                rd_addr_r <= ptr_r;
                                ptr_r <= ptr_inc;
                                bitcnt_r <= 4'h0;
                                state_r <= ldr_pkg::ST_RDATA_ACK;
                            end else begin
                                shift_r <= {shift_r[6:0], 1'b0};
                                oe_n_r <= shift_r[6];
                                bitcnt_r <= bitcnt_r + 4'h1;
                            end
                        end
                    end
                    ldr_pkg::ST_RDATA_ACK: begin
                        // master nack ends the read burst
                        if (scl_rise && sda_s) begin
                            state_r <= ldr_pkg::ST_IDLE;
                        end else if (scl_fall) begin
                            shift_r <= rd_mux;
                            oe_n_r <= rd_mux[7];
                            state_r <= ldr_pkg::ST_RDATA;
                        end
                    end
                    default: begin
                        state_r <= ldr_pkg::ST_IDLE;
                        oe_n_r <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ******************************
    // read multiplexer
    // ******************************
    always_comb begin
        rd_mux = 8'h00;
        case ({4'h0, ptr_r})
            8'h00, 8'h01, 8'h02, 8'h03: rd_mux = {1'b0, cfg_r.cur[ptr_r[1:0]]};
            ldr_pkg::OFS_VREG: rd_mux = {1'b0, cfg_r.vreg};
            8'h05, 8'h06, 8'h07, ldr_pkg::OFS_DRAIN4: begin
                rd_mux = adc_r.drain[2'(ptr_r - ldr_pkg::OFS_DRAIN1[3:0])];
            end
            ldr_pkg::OFS_OVS: rd_mux = {1'b0, adc_r.ovs};
            ldr_pkg::OFS_FAULT: rd_mux = {2'b00, flags_r};
            ldr_pkg::OFS_STBY: rd_mux = {7'h00, cfg_r.standby};
            ldr_pkg::OFS_REV: rd_mux = {5'h00, REVISION};
            default: rd_mux = 8'h00;
        endcase
    end

    // ******************************
    // writable registers
    // ******************************
    logic stby_exit;

    assign stby_exit = wr_en_r && ({4'h0, wr_addr_r} == ldr_pkg::OFS_STBY) &&
        !wr_data_r[ldr_pkg::STBY_BIT] && cfg_r.standby;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            cfg_r.cur <= {ldr_pkg::NUM_STR{ldr_pkg::CUR_RST}};
            cfg_r.vreg <= ldr_pkg::VREG_RST;
            cfg_r.standby <= ldr_pkg::STBY_RST;
        end else if (wr_en_r) begin
            // string currents; frozen in standby, writes to them ignored then
            if ({4'h0, wr_addr_r} < ldr_pkg::OFS_VREG && !cfg_r.standby) begin
                cfg_r.cur[wr_addr_r[1:0]] <= wr_data_r[ldr_pkg::CUR_W-1:0];
            end
            if ({4'h0, wr_addr_r} == ldr_pkg::OFS_VREG && !cfg_r.standby) begin
                cfg_r.vreg <= wr_data_r[ldr_pkg::CUR_W-1:0];
            end
            if ({4'h0, wr_addr_r} == ldr_pkg::OFS_STBY) begin
                cfg_r.standby <= wr_data_r[ldr_pkg::STBY_BIT];
            end
        end
    end

    // ******************************
    // adc result capture
    // ******************************
    // adc results loaded outside standby
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            adc_r.drain <= {ldr_pkg::NUM_STR{ldr_pkg::ADC_RST}};
            adc_r.ovs <= ldr_pkg::OVS_RST;
        end else if (adc_load_i && !cfg_r.standby) begin
            adc_r <= adc_i;
        end
    end

    // ******************************
    // fault qualification and logging
    // ******************************
    logic [ldr_pkg::NUM_FSRC-1:0] flt_d_r;
    logic [ldr_pkg::NUM_FSRC-1:0] flt_q;
    logic [ldr_pkg::FLT_W-1:0] log_ev;
    logic rd_clr;

    // two consecutive samples reject single-clock glitches
    genvar g;
    generate
        for (g = 0; g < ldr_pkg::NUM_FSRC; g++) begin : g_flt
            always_ff @(posedge core_clk_i) begin
                if (sys_rst_i) begin
                    flt_d_r[g] <= 1'b0;
                end else begin
                    flt_d_r[g] <= flt_s[g];
                end
            end
            assign flt_q[g] = flt_s[g] & flt_d_r[g];
        end
    endgenerate

    assign log_ev = (en_s && !cfg_r.standby) ?
        {flt_q[ldr_pkg::NUM_FSRC-1:1], 1'b0, flt_q[0]} : '0;
    // clear after first read following standby cycle
    assign rd_clr = rd_done_r && ({4'h0, rd_addr_r} == ldr_pkg::OFS_FAULT) && arm_r;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            flags_r <= ldr_pkg::FLT_RST;
        end else if (!en_s) begin
            flags_r <= ldr_pkg::FLT_RST;
        end else begin
            // sticky logging; new event beats read clear
            flags_r <= (rd_clr ? ldr_pkg::FLT_RST : flags_r) | log_ev;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            arm_r <= 1'b0;
        end else if (!en_s || rd_clr) begin
            arm_r <= 1'b0;
        end else if (stby_exit) begin
            arm_r <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            halt_r <= 1'b0;
        end else if (!en_s) begin
            halt_r <= 1'b0;
        end else if (log_ev[ldr_pkg::FLT_OVER_BIT]) begin
            halt_r <= 1'b1;
        end else if (stby_exit) begin
            halt_r <= 1'b0;
        end
    end

    // open-drain: only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe_n_o = oe_n_r;
    assign cfg_o = cfg_r;
    assign fault_flags_o = flags_r;
    assign switching_halt_o = halt_r;

    // ******************************
    // assertions
    // ******************************
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    AST_CUR_WRITE: assert property (
        (wr_en_r && wr_addr_r == 4'h2 && !cfg_r.standby) |=> cfg_o.cur[2] == $past(wr_data_r[6:0])
    ) else $error("string current write not applied");

    AST_VREG_WRITE: assert property (
        (wr_en_r && wr_addr_r == 4'h4 && !cfg_r.standby) |=> cfg_o.vreg == $past(wr_data_r[6:0])
    ) else $error("regulator voltage write not applied");

    AST_ADC_HOLD: assert property (
        (!adc_load_i || cfg_r.standby) |=> $stable(adc_r)
    ) else $error("adc result changed without load");

    AST_STBY_NO_LOG: assert property (
        cfg_r.standby |=> (fault_flags_o & ~$past(fault_flags_o)) == 6'h00
    ) else $error("fault logged during standby");

    AST_GLITCH_REJECT: assert property (
        (!flt_s[1] ##1 flt_s[1] ##1 !flt_s[1]) |-> !$rose(fault_flags_o[2])
    ) else $error("one-cycle fault pulse logged");

    AST_ENABLE_CLEAR: assert property (
        !en_s |=> fault_flags_o == 6'h00 && !switching_halt_o
    ) else $error("enable low did not clear faults");

    AST_READ_CLEAR: assert property (
        (rd_clr && log_ev == 6'h00 && en_s) |=> fault_flags_o == 6'h00 && !arm_r
    ) else $error("fault register not cleared by read");

    AST_OVERVOLT_HALT: assert property (
        $rose(fault_flags_o[0]) |-> switching_halt_o
    ) else $error("overvoltage flag without switching halt");

    AST_BIT1_ZERO: assert property (
        fault_flags_o[1] == 1'b0
    ) else $error("unused fault bit set");

    AST_PTR_WRAP: assert property (
        ((wr_en_r || rd_done_r) && $past(ptr_r) == 4'hc) |-> ptr_r == 4'h0
    ) else $error("pointer did not wrap");

    AST_NACK_PTR: assert property (
        (state_r == ldr_pkg::ST_CMD && scl_fall && bitcnt_r == 4'h8 && !cmd_ok && !bus_start
            && !bus_stop) |=> $stable(ptr_r) && state_r == ldr_pkg::ST_IDLE && sda_oe_n_o
    ) else $error("invalid command acknowledged or pointer moved");

    AST_STBY_CMD: assert property (
        (wr_en_r && wr_addr_r == 4'hb) |=> cfg_o.standby == $past(wr_data_r[0])
    ) else $error("standby bit not written");

endmodule

// *** logic/ldr_pkg.sv ***
// constants, types and states of the led driver register file
package ldr_pkg;

    localparam int NUM_STR = 4;
    localparam int PTR_W = 4;
    localparam int CUR_W = 7;
    localparam int ADC_W = 8;
    localparam int OVS_W = 7;
    localparam int FLT_W = 6;
    localparam int REV_W = 3;
    localparam int NUM_FSRC = 5;

    // ******************************
    // register offsets
    // ******************************
    localparam logic [7:0] OFS_CUR1 = 8'h00;
    localparam logic [7:0] OFS_VREG = 8'h04;
    localparam logic [7:0] OFS_DRAIN1 = 8'h05;
    localparam logic [7:0] OFS_DRAIN4 = 8'h08;
    localparam logic [7:0] OFS_OVS = 8'h09;
    localparam logic [7:0] OFS_FAULT = 8'h0a;
    localparam logic [7:0] OFS_STBY = 8'h0b;
    localparam logic [7:0] OFS_REV = 8'h0c;
    localparam logic [7:0] OFS_LAST = 8'h0c;

    // ******************************
    // field positions and reset values
    // ******************************
    localparam int FLT_OVER_BIT = 0;
    localparam int FLT_SHORT_BIT0 = 2;
    localparam int STBY_BIT = 0;
    localparam int ADC_TMO_BIT = 7;
    localparam logic [CUR_W-1:0] CUR_RST = 7'h00;
    localparam logic [CUR_W-1:0] VREG_RST = 7'h00;
    localparam logic [ADC_W-1:0] ADC_RST = 8'h00;
    localparam logic [OVS_W-1:0] OVS_RST = 7'h00;
    localparam logic [FLT_W-1:0] FLT_RST = 6'h00;
    localparam logic STBY_RST = 1'b0;
    localparam int I2C_BITS = 8;

    typedef struct packed {
        logic [NUM_STR-1:0][CUR_W-1:0] cur;
        logic [CUR_W-1:0] vreg;
        logic standby;
    } ldr_cfg_t;

    typedef struct packed {
        logic [NUM_STR-1:0][ADC_W-1:0] drain;
        logic [OVS_W-1:0] ovs;
    } ldr_adc_t;

    typedef struct packed {
        logic [NUM_STR-1:0] shorted;
        logic over_volt;
    } ldr_flt_in_t;

    typedef enum logic [8:0] {
        ST_IDLE      = 9'h001,
        ST_ADDR      = 9'h002,
        ST_ADDR_ACK  = 9'h004,
        ST_CMD       = 9'h008,
        ST_CMD_ACK   = 9'h010,
        ST_WDATA     = 9'h020,
        ST_WDATA_ACK = 9'h040,
        ST_RDATA     = 9'h080,
        ST_RDATA_ACK = 9'h100
    } ldr_i2c_st_t;

endpackage

// *** logic/ldr_sync.sv ***
// two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module ldr_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // first stage read only by the second
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;
endmodule

// *** dv/ldr_i2c_master.sv ***
// behavioural i2c bus master driving the register file pins
`timescale 1ns/1ps
module ldr_i2c_master (
    input wire logic core_clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    // scl stands high between frames, as the pulled-up wire does
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // one change per quarter bit, so scl and sda never move together
    task automatic step(input logic s, input logic l);
        repeat (8) @(posedge core_clk_i);
        scl_o <= s;
        sda_low_o <= l;
    endtask
    // sda moves a quarter after scl fall, clear of the device hold time
    task automatic bit_io(input logic b, output logic r);
        step(1'b0, ~b);
        step(1'b1, ~b);
        repeat (8) @(posedge core_clk_i);
        r = sda_i;
        step(1'b0, ~b);
    endtask
    task automatic start();
        step(scl_o, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask
    task automatic stop();
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task automatic rbyte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~ack, r);
    endtask
endmodule

// *** dv/tb_ldr_regfile.sv ***
// self-checking bench of the led driver register file
`timescale 1ns/1ps
module tb_ldr_regfile;
    localparam logic [6:0] SLV = 7'h2a;
    // arbitrary revision value
    localparam logic [2:0] REV = 3'h5;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic enable_i = 1'b1;
    logic busy_i = 1'b0;
    logic adc_load_i = 1'b0;
    ldr_pkg::ldr_adc_t adc_i = '0;
    ldr_pkg::ldr_flt_in_t fault_i = '0;
    ldr_pkg::ldr_cfg_t cfg_o;
    logic [5:0] fault_flags_o;
    logic scl, sda_low, sda_w, sda_o, sda_oe_n_o, switching_halt_o, ak;
    logic [7:0] rb;
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0;
    int mreg[13] = '{default: 0};
    int ptr = 0;
    int mflt = 0;
    int mhalt = 0;
    int armed = 0;
    int none[$];
    int dq[$];
    logic [31:0] seed = 32'h17;
    // open-drain wire with pull-up
    assign sda_w = (sda_low | ~(sda_oe_n_o | sda_o)) ? 1'b0 : 1'b1;
    ldr_i2c_master m (.core_clk_i(core_clk_i), .sda_i(sda_w), .scl_o(scl), .sda_low_o(sda_low));
    ldr_regfile #(.I2C_ADDR(SLV), .REVISION(REV)) dut (.core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_n_o(sda_oe_n_o), .enable_i(enable_i), .busy_i(busy_i),
        .adc_load_i(adc_load_i), .adc_i(adc_i), .fault_i(fault_i), .cfg_o(cfg_o),
        .fault_flags_o(fault_flags_o), .switching_halt_o(switching_halt_o));
    initial forever #2.5 core_clk_i = ~core_clk_i;
    // about 25k cycles of traffic; the ceiling leaves margin
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_fail++;
            report_and_stop();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic note(input logic ok, input string what);
        samples_checked++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask
    task automatic chk_ack(input logic got, input logic exp);
        note(got === exp, "ack");
    endtask
    task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
        note(got === exp, "read data");
    endtask
    task automatic chk_pin(input logic [35:0] got, input logic [35:0] exp);
        note(got === exp, "port value");
    endtask
    function automatic logic [7:0] mread(int a);
        if (a == 10) return mflt[7:0];
        if (a == 12) return {5'h00, REV};
        return mreg[a][7:0];
    endfunction
    function automatic logic [35:0] mcfg();
        return {mreg[3][6:0], mreg[2][6:0], mreg[1][6:0], mreg[0][6:0], mreg[4][6:0],
            mreg[11][0]};
    endfunction
    // standby blocks the programming registers; leaving it arms the clear
    task automatic mwrite(int a, int d);
        if (a < 5 && mreg[11] == 0) mreg[a] = d & 'h7f;
        if (a == 11 && mreg[11] == 1 && (d & 1) == 0) armed = 1;
        if (a == 11) mreg[11] = d & 1;
    endtask
    task automatic wr(input int cmd, input int d[$]);
        int e;
        m.start();
        m.wbyte({SLV, 1'b0}, ak);
        m.wbyte(cmd[7:0], ak);
        e = (cmd < 13 && busy_i === 1'b0);
        chk_ack(ak, e[0]);
        if (e == 1) ptr = cmd;
        foreach (d[i]) begin
            m.wbyte(d[i][7:0], ak);
            mwrite(ptr, d[i]);
            ptr = (ptr + 1) % 13;
        end
        m.stop();
    endtask
    task automatic wr1(input int cmd, input int d);
        int q1[$];
        q1.push_back(d);
        wr(cmd, q1);
    endtask
    // a negative command reads from the current pointer
    task automatic rd(input int cmd, input int n);
        m.start();
        if (cmd >= 0) begin
            m.wbyte({SLV, 1'b0}, ak);
            m.wbyte(cmd[7:0], ak);
            ptr = cmd;
            m.start();
        end
        m.wbyte({SLV, 1'b1}, ak);
        chk_ack(ak, 1'b1);
        for (int i = 0; i < n; i++) begin
            m.rbyte(i < n - 1, rb);
            chk_rd(rb, mread(ptr));
            if (ptr == 10 && armed == 1) mflt = 0;
            if (ptr == 10) armed = 0;
            ptr = (ptr + 1) % 13;
        end
        m.stop();
    endtask
    task automatic flt(input logic [4:0] f, input int n);
        fault_i <= f;
        repeat (n) @(posedge core_clk_i);
        fault_i <= '0;
        repeat (8) @(posedge core_clk_i);
    endtask
    task automatic report_and_stop();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        repeat (5) @(posedge core_clk_i);
        rd(0, 14);
        dq = {8'hff, 8'hff, 8'hfe, 8'hff};
        repeat (5) dq.push_back(int'(rnd() & 32'hff));
        wr(9, dq);
        chk_pin(cfg_o, mcfg());
        rd(0, 13);
        busy_i <= 1'b1;
        wr(2, none);
        busy_i <= 1'b0;
        wr(13, none);
        wr(255, none);
        rd(-1, 2);
        m.start();
        m.wbyte({7'h2b, 1'b0}, ak);
        chk_ack(ak, 1'b0);
        m.stop();
        // alternate timeout flag across strings
        for (int i = 0; i < 4; i++) begin
            mreg[5 + i] = int'(rnd() & 32'h7f) | ((i % 2) << 7);
            adc_i.drain[i] <= mreg[5 + i][7:0];
        end
        mreg[9] = int'(rnd() & 32'h7f);
        adc_i.ovs <= mreg[9][6:0];
        adc_load_i <= 1'b1;
        @(posedge core_clk_i);
        adc_load_i <= 1'b0;
        rd(5, 5);
        flt(5'h1f, 1);
        chk_pin(36'(fault_flags_o), 36'(mflt));
        flt(5'h05, 4);
        mflt = 'h09;
        mhalt = 1;
        chk_pin(36'(fault_flags_o), 36'(mflt));
        chk_pin(36'(switching_halt_o), 36'(mhalt));
        wr1(11, 1);
        chk_pin(cfg_o, mcfg());
        flt(5'h10, 4);
        wr1(0, 'h33);
        // a load while in standby must not reach the adc registers
        adc_i <= ~adc_i;
        adc_load_i <= 1'b1;
        @(posedge core_clk_i);
        adc_load_i <= 1'b0;
        wr1(11, 0);
        mhalt = 0;
        chk_pin(cfg_o, mcfg());
        chk_pin(36'(fault_flags_o), 36'(mflt));
        chk_pin(36'(switching_halt_o), 36'(mhalt));
        rd(5, 5);
        rd(10, 1);
        rd(10, 1);
        flt(5'h03, 4);
        mflt = 'h05;
        mhalt = 1;
        chk_pin(36'(fault_flags_o), 36'(mflt));
        chk_pin(36'(switching_halt_o), 36'(mhalt));
        enable_i <= 1'b0;
        repeat (8) @(posedge core_clk_i);
        enable_i <= 1'b1;
        repeat (8) @(posedge core_clk_i);
        mflt = 0;
        mhalt = 0;
        chk_pin(36'(fault_flags_o), 36'(mflt));
        chk_pin(36'(switching_halt_o), 36'(mhalt));
        report_and_stop();
    end
endmodule
